// >>> src/ext_bus_pins.sv
// External memory bus: pin ownership, bus cycles and AHB-Lite control registers
// Summary of operation
// [RULE1] Microcontroller-only mode: no bus, port pins only, control writes refused.
// [RULE2] Extended mode: external fetch or table access puts pins on bus.
// [RULE3] Internal-only activity: release bit 0 gives bus, 1 gives ports.
// [RULE4] Release bit 1 with external access: bus overrides ports for it.
// [RULE5] Release set from external code takes effect on branch to internal.
// [RULE6] Bus idle internal: data tri-state, strobes high, latch and byte bit low.
// [RULE7] Only pins inside the configured address width are taken by bus.
// [RULE8] Bus wins shared pins over every other peripheral.
// [RULE9] 16-bit width: write configuration from two-bit write mode field.
// [RULE10] Field 1x word write, 01 byte select, 00 byte write; no 8-bit effect.
// [RULE11] 16-bit: latch strobe with address, then output enable reads whole word.
// [RULE12] Chip enable low during every access, high throughout Sleep.
// [RULE13] Byte write: latch byte on both halves, high or low strobe by pointer.
// [RULE14] Word write even: hold byte, tri-state data portion, no strobe.
// [RULE15] Word write odd: latch byte upper, held byte lower.
// [RULE16] Word write: high strobe on odd write, pointer bit out, both enables.
// [RULE17] Byte select: both halves, high strobe, byte bit or enables pick byte.
// [RULE18] Flash uses byte bit plus port select; SRAM uses byte enables.
// [RULE19] 8-bit width: multiplexed only, data on low eight lines.
// [RULE20] 8-bit fetch: two bytes per cycle, byte bit toggles between them.
// [RULE21] 8-bit memory answers in half a cycle, byte bit as address bit.
// [RULE22] 8-bit table write: both halves, byte bit from pointer.
// [RULE23] Sleep and Idle: bus frozen, chip and byte enables held high.
`timescale 1ns/1ps
module ext_bus_pins #(
  parameter int PHASE_CYCLES = ebus_pkg::PHASE_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Core fetch and table unit
  input  wire logic        core_req,
  input  wire logic [1:0]  core_op,
  input  wire logic [20:0] core_addr,
  input  wire logic        core_ext,
  input  wire logic        core_exec_ext,
  input  wire logic [7:0]  table_latch,
  input  wire logic        core_sleep,
  output logic             core_busy,
  output logic             core_done,
  output logic      [15:0] core_rdata,
  // Port side values of the shared pins
  input  wire logic [15:0] port_ad_out,
  input  wire logic [15:0] port_ad_oe,
  input  wire logic [3:0]  port_hi_out,
  input  wire logic [3:0]  port_hi_oe,
  input  wire logic [7:0]  port_ctl_out,
  input  wire logic [7:0]  port_ctl_oe,
  // Pins
  input  wire logic [15:0] ad_in,
  output logic      [15:0] ad_out,
  output logic      [15:0] ad_oe,
  output logic      [3:0]  a_hi_out,
  output logic      [3:0]  a_hi_oe,
  output logic      [7:0]  ctl_out,
  output logic      [7:0]  ctl_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_LATCH, ST_DATA1, ST_DATA2} bus_state_e;

  bus_state_e  state_reg;
  logic [7:0]  bus_control_reg;
  logic [2:0]  cfg_reg;
  logic        release_eff_reg;
  logic        wr_ph_reg;
  logic [7:0]  ofs_ph_reg;
  logic [1:0]  op_reg;
  logic [20:0] addr_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  hold_reg;
  logic [15:0] ad_meta_reg;
  logic [15:0] ad_sync_reg;
  logic        tick;

  pin_sel_if #(.W(16)) ad_if ();
  pin_sel_if #(.W(4))  hi_if ();
  pin_sel_if #(.W(8))  ctl_if ();

  initial begin
    if (PHASE_CYCLES < 3 || PHASE_CYCLES > 255) $error("ext_bus_pins: bad PHASE_CYCLES");
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire         mcu_mode   = (cfg_reg[1:0] == ebus_pkg::MCU_ONLY);
  wire         data16     = cfg_reg[ebus_pkg::DATA16_BIT];
  wire         bus_rel    = bus_control_reg[ebus_pkg::RELEASE_BIT];
  wire         wm_word    = data16 & bus_control_reg[ebus_pkg::WM_HI_BIT];  // RULE10
  wire         wm_bsel    = data16 & ~bus_control_reg[ebus_pkg::WM_HI_BIT]
                            & bus_control_reg[ebus_pkg::WM_LO_BIT];         // RULE10
  wire         wm_byte    = data16 & (bus_control_reg[1:0] == 2'h0);        // RULE10
  wire         is_write   = (op_reg == ebus_pkg::OP_TABLE_WRITE_OP);
  wire         ptr0       = addr_reg[0];
  wire         word_even  = is_write & wm_word & ~ptr0;                     // RULE14
  wire         in_access  = (state_reg != ST_IDLE);
  wire         addr_phase = (state_reg == ST_ADDR) | (state_reg == ST_LATCH);
  wire         data_phase = (state_reg == ST_DATA1) | (state_reg == ST_DATA2);
  wire [19:0]  word_addr  = addr_reg[20:1];

  // ----------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------
  wire use_bus = ~mcu_mode & (in_access | ~release_eff_reg); // RULE1 RULE2 RULE3 RULE4
  wire [15:0] ad_mask = mcu_mode ? 16'h0000 :
                        (cfg_reg[1:0] == ebus_pkg::WIDTH_12) ? ebus_pkg::AD_MASK_12 :
                        ebus_pkg::AD_MASK_FULL; // RULE7
  wire [3:0]  hi_mask = (cfg_reg[1:0] == ebus_pkg::WIDTH_20) ? 4'hF : 4'h0;  // RULE7

  // ----------------------------------------------------------------
  // Data driven in the data portion
  // ----------------------------------------------------------------
  wire [15:0] wr_word = (wm_word & ptr0) ? {wdata_reg, hold_reg} // RULE15
                                         : {wdata_reg, wdata_reg}; // RULE13 RULE17 RULE22
  wire        drive_hi_addr = ~data16; // RULE19
  wire [15:0] data_out = is_write ? wr_word
                       : {word_addr[15:8], 8'h00};
  wire [15:0] data_oe  = word_even ? 16'h0000 : // RULE14
                         is_write ? 16'hFFFF :
                         drive_hi_addr ? 16'hFF00 : 16'h0000; // RULE19

  wire [15:0] bus_ad_out = addr_phase ? word_addr[15:0] :
                           data_phase ? data_out : 16'h0000;
  wire [15:0] bus_ad_oe  = addr_phase ? 16'hFFFF :
                           data_phase ? data_oe : 16'h0000; // RULE6

  // ----------------------------------------------------------------
  // Control strobes
  // ----------------------------------------------------------------
  wire wr_strobe = is_write & (state_reg == ST_DATA2) & ~word_even; // RULE14
  wire wrh_act   = wr_strobe & (~wm_byte | ptr0); // RULE13 RULE16 RULE17
  wire wrl_act   = wr_strobe & wm_byte & ~ptr0; // RULE13
  wire oe_act    = ~is_write & data_phase; // RULE11
  wire ba0_val   = is_write ? ptr0 : // RULE16 RULE17 RULE22
                   (~data16 & (state_reg == ST_DATA2)); // RULE20
  wire ub_act    = in_access & ~(is_write & wm_bsel & ~ptr0); // RULE16 RULE17
  wire lb_act    = in_access & ~(is_write & wm_bsel & ptr0); // RULE16 RULE17

  logic [7:0] bus_ctl;
  always_comb begin
    bus_ctl                    = ebus_pkg::CTL_IDLE; // RULE6
    bus_ctl[ebus_pkg::CTL_ALE] = (state_reg == ST_ADDR); // RULE11
    bus_ctl[ebus_pkg::CTL_OE]  = ~oe_act;
    bus_ctl[ebus_pkg::CTL_WRL] = ~wrl_act;
    bus_ctl[ebus_pkg::CTL_WRH] = ~wrh_act;
    bus_ctl[ebus_pkg::CTL_BA0] = in_access & ba0_val;
    bus_ctl[ebus_pkg::CTL_CE]  = ~in_access | core_sleep; // RULE12 RULE23
    bus_ctl[ebus_pkg::CTL_LB]  = ~lb_act | core_sleep; // RULE23
    bus_ctl[ebus_pkg::CTL_UB]  = ~ub_act | core_sleep; // RULE23
  end

  // ----------------------------------------------------------------
  // Pin muxes
  // ----------------------------------------------------------------
  assign ad_if.bus_out   = bus_ad_out;
  assign ad_if.bus_oe    = bus_ad_oe;
  assign ad_if.bus_mask  = ad_mask;
  assign ad_if.port_out  = port_ad_out;
  assign ad_if.port_oe   = port_ad_oe;
  assign ad_if.use_bus   = use_bus;
  assign hi_if.bus_out   = word_addr[19:16];
  assign hi_if.bus_oe    = {4{in_access}};
  assign hi_if.bus_mask  = hi_mask;
  assign hi_if.port_out  = port_hi_out;
  assign hi_if.port_oe   = port_hi_oe;
  assign hi_if.use_bus   = use_bus;
  assign ctl_if.bus_out  = bus_ctl;
  assign ctl_if.bus_oe   = 8'hFF;
  assign ctl_if.bus_mask = 8'hFF;
  assign ctl_if.port_out = port_ctl_out;
  assign ctl_if.port_oe  = port_ctl_oe;
  assign ctl_if.use_bus  = use_bus;

  pin_owner_mux #(.W(16)) u_ad_mux (.hclk(hclk), .hresetn(hresetn), .sel(ad_if));   // RULE8
  pin_owner_mux #(.W(4))  u_hi_mux (.hclk(hclk), .hresetn(hresetn), .sel(hi_if));   // RULE8
  pin_owner_mux #(.W(8))  u_ctl_mux (.hclk(hclk), .hresetn(hresetn), .sel(ctl_if)); // RULE8

  assign ad_out   = ad_if.pin_out;
  assign ad_oe    = ad_if.pin_oe;
  assign a_hi_out = hi_if.pin_out;
  assign a_hi_oe  = hi_if.pin_oe;
  assign ctl_out  = ctl_if.pin_out;
  assign ctl_oe   = ctl_if.pin_oe;

  // ----------------------------------------------------------------
  // Phase divider and pin input synchroniser
  // ----------------------------------------------------------------
  phase_tick_gen #(.CYCLES(PHASE_CYCLES)) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ad_meta_reg <= 16'h0000;
      ad_sync_reg <= 16'h0000;
    end else begin
      ad_meta_reg <= ad_in;
      ad_sync_reg <= ad_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Deferred bus release
  // ----------------------------------------------------------------
  wire release_next = mcu_mode ? 1'b0 : // RULE1
                      (~core_exec_ext | ~bus_rel) ? bus_rel : release_eff_reg;  // RULE5

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) release_eff_reg <= 1'b0;
    else          release_eff_reg <= release_next;
  end

  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  wire take_req  = ~in_access & ~core_busy & core_req & ~core_sleep;
  wire take_ext  = take_req & core_ext & ~mcu_mode; // RULE2
  wire advance   = tick & ~core_sleep; // RULE23
  wire last_ph   = advance & (state_reg == ST_DATA2);
  wire rd_lo_cap = advance & ~is_write & ~data16 & (state_reg == ST_DATA1);  // RULE20
  wire rd_cap    = last_ph & ~is_write;

  bus_state_e state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (take_ext) state_next = ST_ADDR;
      ST_ADDR:  if (advance) state_next = ST_LATCH;
      ST_LATCH: if (advance) state_next = ST_DATA1;
      ST_DATA1: if (advance) state_next = ST_DATA2;
      ST_DATA2: if (advance) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      op_reg    <= 2'h0;
      addr_reg  <= 21'h000000;
      wdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (take_ext) begin
        op_reg    <= core_op;
        addr_reg  <= core_addr;
        wdata_reg <= table_latch;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hold_reg <= 8'h00;
    else if (last_ph & word_even) hold_reg <= wdata_reg; // RULE14
  end

  // Pin register and two sync stages: captures and done trail by three
  logic [8:0] cap_dly_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_dly_reg <= 9'h000;
      core_rdata  <= 16'h0000;
      core_done   <= 1'b0;
      core_busy   <= 1'b0;
    end else begin
      cap_dly_reg <= {cap_dly_reg[5:0], rd_lo_cap, rd_cap, last_ph};
      core_done <= cap_dly_reg[6] | (take_req & ~take_ext);
      core_busy <= (state_next != ST_IDLE) | last_ph | cap_dly_reg[0] | cap_dly_reg[3];
      if (cap_dly_reg[8]) core_rdata[7:0] <= ad_sync_reg[7:0]; // RULE20
      if (cap_dly_reg[7] & data16) core_rdata <= ad_sync_reg; // RULE11
      if (cap_dly_reg[7] & ~data16) core_rdata[15:8] <= ad_sync_reg[7:0]; // RULE19
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite register slave
  // ----------------------------------------------------------------
  wire       accept   = hsel & hready & (htrans == ebus_pkg::HTRANS_NONSEQ);
  wire       rd_ctrl  = (haddr == ebus_pkg::BUS_CTRL_OFS);
  wire       rd_cfg   = (haddr == ebus_pkg::CFG_OFS);
  wire       rd_stat  = (haddr == ebus_pkg::STATUS_OFS);
  wire       rd_word  = (haddr == ebus_pkg::WORD_OFS);
  wire [31:0] status_word = {16'h0000, hold_reg, 4'h0, release_eff_reg, in_access,
                             use_bus, core_sleep};
  wire [31:0] rd_data = rd_ctrl ? {24'h000000, bus_control_reg} :
                        rd_cfg  ? {29'h00000000, cfg_reg} :
                        rd_stat ? status_word :
                        rd_word ? {16'h0000, core_rdata} : 32'h00000000;
  wire       wr_ctrl  = wr_ph_reg & (ofs_ph_reg == ebus_pkg::BUS_CTRL_OFS) & ~mcu_mode;  // RULE1
  wire       wr_cfg   = wr_ph_reg & (ofs_ph_reg == ebus_pkg::CFG_OFS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_reg  <= 1'b0;
      ofs_ph_reg <= 8'h00;
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wr_ph_reg  <= accept & hwrite;
      ofs_ph_reg <= haddr;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      if (accept & ~hwrite) hrdata <= rd_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_control_reg <= ebus_pkg::BUS_CTRL_RST;
      cfg_reg         <= ebus_pkg::CFG_RST;
    end else begin
      if (wr_ctrl) bus_control_reg <= hwdata[7:0] & ebus_pkg::BUS_CTRL_MASK;  // RULE9
      if (wr_cfg)  cfg_reg <= hwdata[2:0];
    end
  end

endmodule : ext_bus_pins

// >>> src/ebus_pkg.sv
// Package: register map, fields, modes and timing of the external memory bus
package ebus_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] BUS_CTRL_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS      = 8'h04;
  localparam logic [7:0] STATUS_OFS   = 8'h08;
  localparam logic [7:0] WORD_OFS     = 8'h0C;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int         RELEASE_BIT   = 7;
  localparam int         WM_HI_BIT     = 1;
  localparam int         WM_LO_BIT     = 0;
  localparam int         DATA16_BIT    = 2;
  localparam logic [7:0] BUS_CTRL_RST  = 8'h00;
  localparam logic [7:0] BUS_CTRL_MASK = 8'hB3;
  localparam logic [2:0] CFG_RST       = 3'h4;

  // Control pin positions
  localparam int CTL_ALE = 0;
  localparam int CTL_OE  = 1;
  localparam int CTL_WRL = 2;
  localparam int CTL_WRH = 3;
  localparam int CTL_BA0 = 4;
  localparam int CTL_CE  = 5;
  localparam int CTL_LB  = 6;
  localparam int CTL_UB  = 7;
  localparam logic [7:0] CTL_IDLE = 8'hEE;

  // Address width masks
  localparam logic [15:0] AD_MASK_FULL = 16'hFFFF;
  localparam logic [15:0] AD_MASK_12   = 16'h0FFF;

  // ----------------------------------------------------------------
  // Modes and commands
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {WIDTH_20, WIDTH_16, WIDTH_12, MCU_ONLY} width_cfg_e;
  typedef enum logic [1:0] {OP_FETCH, OP_TBLRD, OP_TABLE_WRITE_OP} core_op_e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int PHASE_TIME_NS = 300;
  localparam int PHASE_CYCLES  = (PHASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : ebus_pkg

// >>> src/pin_sel_if.sv
// Interface: bus and port values for one group of shared pins
`timescale 1ns/1ps
interface pin_sel_if #(parameter int W = 8);
  logic [W-1:0] bus_out;
  logic [W-1:0] bus_oe;
  logic [W-1:0] bus_mask;
  logic [W-1:0] port_out;
  logic [W-1:0] port_oe;
  logic         use_bus;
  logic [W-1:0] pin_out;
  logic [W-1:0] pin_oe;
  modport ctrl (output bus_out, bus_oe, bus_mask, port_out, port_oe, use_bus,
                input  pin_out, pin_oe);
  modport mux  (input  bus_out, bus_oe, bus_mask, port_out, port_oe, use_bus,
                output pin_out, pin_oe);
endinterface : pin_sel_if

// >>> src/phase_tick_gen.sv
// Divider: free-running one-cycle tick every CYCLES clocks, in the last cycle of each bus phase
`timescale 1ns/1ps
module phase_tick_gen #(
  parameter int CYCLES = ebus_pkg::PHASE_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);
  logic [7:0] cnt_reg;

  initial begin
    if (CYCLES < 3 || CYCLES > 255) $error("phase_tick_gen: CYCLES out of range");
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b0;
    end else begin
      tick    <= (cnt_reg == 8'(CYCLES - 1));
      cnt_reg <= (cnt_reg == 8'(CYCLES - 1)) ? 8'h00 : cnt_reg + 8'h01;
    end
  end
endmodule : phase_tick_gen

// >>> src/pin_owner_mux.sv
// Pin owner mux: registers bus or port values onto a group of pins
`timescale 1ns/1ps
module pin_owner_mux #(
  parameter int W = 8
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  pin_sel_if.mux    sel
);
  logic [W-1:0] own;

  assign own = {W{sel.use_bus}} & sel.bus_mask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel.pin_out <= '0;
      sel.pin_oe  <= '0;
    end else begin
      sel.pin_out <= (sel.bus_out & own) | (sel.port_out & ~own);
      sel.pin_oe  <= (sel.bus_oe & own) | (sel.port_oe & ~own);
    end
  end
endmodule : pin_owner_mux

// >>> bench/ebus_assertions.sv
// Checker: port properties of the external memory bus block
`timescale 1ns/1ps
module ebus_assertions #(
  parameter int PHASE_CYCLES = 3
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        core_sleep,
  input wire logic        core_busy,
  input wire logic        core_done,
  input wire logic [15:0] ad_oe,
  input wire logic [7:0]  ctl_out,
  input wire logic [7:0]  ctl_oe
);
  // ----------------------------------------------------------------
  // Properties on bus-owned pins, the AHB answer and the core handshake
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic bus;
  logic strobe;
  assign bus    = ctl_oe == 8'hFF;
  assign strobe = bus && !(ctl_out[3] && ctl_out[2]);

  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bad answer");
  done_pulse_a: assert property (core_done |=> !core_done)
    else $error("done pulse too long");
  idle_pins_a: assert property (
    bus && !core_busy && !$past(core_busy) && !core_sleep && !$past(core_sleep)
    |-> ctl_out == ebus_pkg::CTL_IDLE && ad_oe[11:0] == 12'h000)
    else $error("idle pattern wrong");
  ale_first_a: assert property (
    bus && $fell(ctl_out[1]) && !ctl_out[4]
    |-> $past(ctl_out[0], PHASE_CYCLES + 1) && !ctl_out[0])
    else $error("no latch first");
  ale_chip_a: assert property (bus && ctl_out[0] |-> !ctl_out[5] && ctl_out[1])
    else $error("latch off chip");
  strobe_chip_a: assert property (strobe |-> !ctl_out[5] && ctl_out[1] && !ctl_out[0])
    else $error("bad strobe");
  sleep_high_a: assert property (
    bus && core_sleep && $past(core_sleep) |-> ctl_out[7:5] == 3'b111)
    else $error("sleep enables");
  access_end_a: assert property ($rose(core_busy) |-> ##[1:40] core_done)
    else $error("access never ends");

  write_seen_c: cover property (strobe);
  read_seen_c: cover property (bus && $fell(ctl_out[1]));
  sleep_seen_c: cover property (bus && core_sleep);
endmodule : ebus_assertions

// >>> bench/ext_mem_model.sv
// Model: external parallel memory answering bus reads
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic        hclk,
  input  wire logic        data16,
  input  wire logic [15:0] ad_out,
  input  wire logic [15:0] ad_oe,
  input  wire logic [7:0]  ctl_out,
  input  wire logic [7:0]  ctl_oe,
  output logic      [15:0] ad_in
);
  // ----------------------------------------------------------------
  // Latched address, read data, released lines
  // ----------------------------------------------------------------
  logic [15:0] addr_q = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] word;
  logic [15:0] drv;
  logic        rd_en;
  assign rd_en = ctl_oe == 8'hFF && !ctl_out[5] && !ctl_out[1];
  assign word  = addr_q ^ 16'h5A3C;
  assign drv   = !rd_en ? ~last_q : data16 ? word
               : {~last_q[15:8], ctl_out[4] ? word[15:8] : word[7:0]};
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & drv);
  always_ff @(posedge hclk) begin
    if (ctl_oe[0] && ctl_out[0]) addr_q <= ad_out;
    last_q <= drv;
  end
endmodule : ext_mem_model

// >>> bench/tb.sv
// Testbench: directed and random scenarios for the external memory bus block
`timescale 1ns/1ps
module tb;
  localparam int PC = 3;
  localparam logic [7:0] CT = ebus_pkg::BUS_CTRL_OFS;
  localparam logic [7:0] CF = ebus_pkg::CFG_OFS;
  localparam logic [1:0] FE = ebus_pkg::OP_FETCH;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, core_req, core_ext;
  logic        core_exec_ext, core_sleep, core_busy, core_done, d16, wh, wl, ce_lo, ba, dn;
  logic [1:0]  htrans, core_op, en;
  logic [2:0]  hsize;
  logic [3:0]  port_hi_out, port_hi_oe, a_hi_out, a_hi_oe;
  logic [7:0]  haddr, table_latch, port_ctl_out, port_ctl_oe, ctl_out, ctl_oe, held, tl;
  logic [15:0] core_rdata, port_ad_out, port_ad_oe, ad_in, ad_out, ad_oe, wd;
  logic [20:0] core_addr;
  logic [31:0] hwdata, hrdata, rd;
  int          seed, miscompares, samples_checked, cyc;

  ext_bus_pins #(.PHASE_CYCLES(PC)) ext_bus_pins_i (.*, .hready(hreadyout));
  ext_mem_model ext_mem_model_i (.*, .data16(d16));

  // ----------------------------------------------------------------
  // Clock, timeout, bus and core tasks
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input string what = "");
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, ebus_pkg::HTRANS_NONSEQ, a, w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    if (!w) chk(rd, d, what);
  endtask : ahb
  task automatic acc(input logic [1:0] op, input logic [20:0] a, input logic ext);
    @(posedge hclk);
    tl = 8'($random(seed));
    {core_req, core_op, core_addr, core_ext, table_latch} <= {1'b1, op, a, ext, tl};
    @(posedge hclk);
    core_req <= 1'b0;
    {wh, wl, ce_lo, en, ba, wd, dn} = '0;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(posedge hclk);
      dn = core_done === 1'b1;
      if (ctl_oe == 8'hFF && !ctl_out[5]) ce_lo = 1'b1;
      if (ctl_oe == 8'hFF && !(ctl_out[3] && ctl_out[2])) begin
        {wh, wl} = {wh | !ctl_out[3], wl | !ctl_out[2]};
        {en, ba, wd} = {ctl_out[7:6], ctl_out[4], ad_out};
      end
    end
  endtask : acc
  task automatic ports();
    @(posedge hclk);
    {port_ad_out, port_hi_out, port_hi_oe} <= {16'($random(seed)), 8'($random(seed))};
    port_ad_oe <= 16'($random(seed)) | 16'h0001;
    port_ctl_out <= 8'($random(seed)) | 8'h20;
    port_ctl_oe <= 8'($random(seed)) & 8'h7F;
    repeat (3) @(posedge hclk);
  endtask : ports
  task automatic fet(input logic x, input logic [1:0] e, input string what);
    acc(FE, 21'($random(seed)), x);
    chk({ce_lo, dn}, e, what);
  endtask : fet
  task automatic pins(input logic bus);
    ports();
    chk({ad_oe, ctl_out, ctl_oe}, bus ? {16'h0000, ebus_pkg::CTL_IDLE, 8'hFF}
        : {port_ad_oe, port_ctl_out, port_ctl_oe}, "pin owner");
  endtask : pins
  function automatic logic [19:0] exp_wr(logic [1:0] m, logic p, logic [7:0] l, logic [7:0] h);
    if (!d16) return {l, l, 4'b1000};
    if (m[1]) return p ? {l, h, 4'b1000} : 20'h00000;
    if (m == 2'b01) return {l, l, 2'b10, !p, p};
    return {l, l, p, !p, 2'b00};
  endfunction : exp_wr

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 72;
    {hresetn, hsel, hwrite, core_req, core_ext, core_exec_ext, core_sleep, d16} = 8'h01;
    {htrans, core_op, haddr, table_latch, core_addr, hwdata} = '0;
    {port_hi_out, port_hi_oe, port_ctl_out, port_ctl_oe, port_ad_out, port_ad_oe} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, CT, {24'h0, ebus_pkg::BUS_CTRL_RST}, "ctrl reset");
    ahb(1'b0, CF, {29'h0, ebus_pkg::CFG_RST}, "cfg reset");
    ahb(1'b1, 8'h40, 32'hFFFFFFFF);
    ahb(1'b0, 8'h40, 32'h0, "unmapped");
    ahb(1'b1, CT, 32'hFF);
    ahb(1'b0, CT, {24'h0, ebus_pkg::BUS_CTRL_MASK}, "ctrl mask");
    $display("test registers done");
    for (int w = 1; w >= 0; w--) begin
      d16 = w[0];
      ahb(1'b1, CF, {29'h0, w[0], 2'b00});
      for (int m = 0; m < 4; m++) begin
        ahb(1'b1, CT, 32'(m));
        for (int p = 0; p < 2; p++) begin
          acc(ebus_pkg::OP_TABLE_WRITE_OP, {20'($random(seed)), p[0]}, 1'b1);
          chk({wd, wh, wl, en}, exp_wr(m[1:0], p[0], tl, held), "write");
          if ((wh || wl) && (m != 0 || !d16)) chk(ba, p[0], "byte bit");
          chk({ce_lo, dn}, 2'b11, "write access");
          if (d16 && m[1] && !p[0]) held = tl;
        end
      end
      for (int k = 0; k < 4; k++) begin
        acc(k[0] ? ebus_pkg::OP_TBLRD : FE, 21'($random(seed)), 1'b1);
        chk(core_rdata, core_addr[16:1] ^ 16'h5A3C, "read word");
      end
    end
    $display("test transfers done");
    d16 = 1'b1;
    ahb(1'b1, CF, 32'h4);
    ahb(1'b1, CT, 32'h0);
    pins(1'b1);
    fet(1'b0, 2'b01, "internal fetch");
    ahb(1'b1, CT, 32'h80);
    pins(1'b0);
    fet(1'b1, 2'b11, "override");
    core_exec_ext <= 1'b1;
    ahb(1'b1, CT, 32'h0);
    ahb(1'b1, CT, 32'h80);
    pins(1'b1);
    core_exec_ext <= 1'b0;
    pins(1'b0);
    ahb(1'b0, ebus_pkg::STATUS_OFS, {16'h0, held, 8'h08}, "status");
    $display("test ownership done");
    ahb(1'b1, CT, 32'h0);
    ahb(1'b1, CF, 32'h6);
    ports();
    chk({ad_out[15:12], ad_oe}, {port_ad_out[15:12], port_ad_oe[15:12], 12'h000}, "narrow");
    ahb(1'b1, CF, 32'h5);
    ports();
    chk({a_hi_out, a_hi_oe}, {port_hi_out, port_hi_oe}, "upper lines");
    ahb(1'b1, CF, 32'h7);
    ahb(1'b1, CT, 32'h83);
    ahb(1'b0, CT, 32'h0, "refused write");
    pins(1'b0);
    fet(1'b1, 2'b01, "no bus");
    $display("test modes done");
    ahb(1'b1, CF, 32'h4);
    core_sleep <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({ctl_out[7:5], ad_oe}, {3'b111, 16'h0000}, "sleep pins");
    fet(1'b1, 2'b00, "sleep refusal");
    core_sleep <= 1'b0;
    $display("test sleep done");
    wrap_up();
  end
endmodule : tb

bind ext_bus_pins ebus_assertions #(.PHASE_CYCLES(PHASE_CYCLES)) ebus_assertions_i (.*);
